/* File: hw/branch_bit_instruction_exec.sv */
// What this block does
// [RQ1] skip io bit clear: skip next when io bit is zero, flags kept
// [RQ2] skip io bit set: skip next instruction when io bit is one, flags kept
// [RQ3] generic flag branch on status bit s set or clear to pc+k+1
// [RQ4] equal branch on zero one, not-equal branch on zero zero
// [RQ5] carry set and lower on carry one; carry clear, same-higher on zero
// [RQ6] minus branch on negative one, plus branch on negative zero
// [RQ7] signed greater-or-equal taken when negative xor overflow is zero
// [RQ8] signed less-than taken when negative xor overflow is one
// [RQ9] half-carry branches on half-carry one or zero, flags unchanged
// [RQ10] transfer-bit branches on transfer bit one or zero
// [RQ11] overflow branches on overflow flag one or zero
// [RQ12] interrupt enabled or disabled branches on global enable bit
// [RQ13] branch one cycle untaken, two taken; skip one, two or three
// [RQ14] io bit force one or zero in two cycles, flags untouched
// [RQ15] logical left shift, zero into bit 0, updates z c n v
// [RQ16] logical right shift, zero into bit 7, updates z c n v
// [RQ17] rotate left through carry, old bit 7 to carry
// [RQ18] rotate right through carry, old bit 0 to carry
// [RQ19] arithmetic right shift keeps bit 7, updates z c n v
// [RQ20] bit store copies register bit into transfer bit only
// [RQ21] bit load copies transfer bit into register bit, flags kept
// [RQ22] carry and negative flag set and clear touch only that flag
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`default_nettype none
module branch_bit_instruction_exec
  import bit_exec_pkg::*;
#(
  parameter int PC_W = PC_WIDTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire instr_s instr_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0] io_rd_data_in,
  input wire logic status_wr_in,
  input wire logic [7:0] status_wdata_in,
  output logic ready_out,
  output logic [IO_ADDR_W-1:0] io_rd_addr_out,
  output io_wr_s io_wr_out,
  output reg_wr_s reg_wr_out,
  output logic [PC_W-1:0] pc_out,
  output logic [7:0] status_out,
  output logic [1:0] cycles_out,
  output logic done_out
);

  function automatic logic [PC_W-1:0] rel_target(
    input logic [PC_W-1:0] pc,
    input logic [OFFSET_W-1:0] k
  );
    logic [PC_W-1:0] k_ext;
    k_ext = PC_W'($signed(k));
    return PC_W'(pc + k_ext + PC_W'(1));
  endfunction : rel_target

  function automatic logic [7:0] shift_flags(
    input logic [7:0] st,
    input logic [7:0] res,
    input logic carry
  );
    logic [7:0] f;
    f = st;
    f[FLAG_Z] = (res == 8'h00);
    f[FLAG_C] = carry;
    f[FLAG_N] = res[7];
    f[FLAG_V] = res[7] ^ carry;
    return f;
  endfunction : shift_flags

  // io bit operations fetch the location combinationally
  assign io_rd_addr_out = instr_in.io_addr;

  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [1:0] remain_q;
  logic [1:0] remain_d;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic [1:0] cycles_q;
  logic [1:0] cycles_d;
  logic done_q;
  logic done_d;
  reg_wr_s reg_wr_q;
  reg_wr_s reg_wr_d;
  io_wr_s io_pend_q;
  io_wr_s io_pend_d;
  io_wr_s io_wr_q;
  io_wr_s io_wr_d;

  logic accept;
  logic cond;
  logic is_branch;
  logic is_skip;
  logic io_bit;
  logic [7:0] res;
  logic io_force;
  logic io_force_one;

  assign ready_out = (remain_q == 2'h0);
  assign accept = instr_valid_in && ready_out;
  assign io_bit = io_rd_data_in[instr_in.bit_idx];
  assign io_force_one = (instr_in.op == OP_IO_BIT_FORCE_ONE);
  assign io_force = io_force_one || (instr_in.op == OP_IO_BIT_FORCE_ZERO);

  // branch and skip condition select
  always_comb begin
    cond = 1'b0;
    is_branch = 1'b1;
    is_skip = 1'b0;
    case (instr_in.op)
      OP_SKIP_IO_BIT_CLEAR: begin
        is_branch = 1'b0;
        is_skip = 1'b1;
        cond = !io_bit; // RQ1
      end
      OP_SKIP_IO_BIT_SET: begin
        is_branch = 1'b0;
        is_skip = 1'b1;
        cond = io_bit; // RQ2
      end
      OP_BRANCH_FLAG_INDEX_SET: begin
        cond = status_q[instr_in.bit_idx]; // RQ3
      end
      OP_BRANCH_FLAG_INDEX_CLEAR: begin
        cond = !status_q[instr_in.bit_idx]; // RQ3
      end
      OP_BRANCH_EQUAL: begin
        cond = status_q[FLAG_Z]; // RQ4
      end
      OP_BRANCH_NOT_EQUAL: begin
        cond = !status_q[FLAG_Z]; // RQ4
      end
      OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: begin
        cond = status_q[FLAG_C]; // RQ5
      end
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER: begin
        cond = !status_q[FLAG_C]; // RQ5
      end
      OP_BRANCH_MINUS: begin
        cond = status_q[FLAG_N]; // RQ6
      end
      OP_BRANCH_PLUS: begin
        cond = !status_q[FLAG_N]; // RQ6
      end
      OP_BRANCH_SIGNED_GE: begin
        cond = !(status_q[FLAG_N] ^ status_q[FLAG_V]); // RQ7
      end
      OP_BRANCH_SIGNED_LT: begin
        cond = status_q[FLAG_N] ^ status_q[FLAG_V]; // RQ8
      end
      OP_BRANCH_HALF_CARRY_SET: begin
        cond = status_q[FLAG_H]; // RQ9
      end
      OP_BRANCH_HALF_CARRY_CLEAR: begin
        cond = !status_q[FLAG_H]; // RQ9
      end
      OP_BRANCH_TRANSFER_SET: begin
        cond = status_q[FLAG_T]; // RQ10
      end
      OP_BRANCH_TRANSFER_CLEAR: begin
        cond = !status_q[FLAG_T]; // RQ10
      end
      OP_BRANCH_OVERFLOW_SET: begin
        cond = status_q[FLAG_V]; // RQ11
      end
      OP_BRANCH_OVERFLOW_CLEAR: begin
        cond = !status_q[FLAG_V]; // RQ11
      end
      OP_BRANCH_IRQ_ENABLED: begin
        cond = status_q[FLAG_I]; // RQ12
      end
      OP_BRANCH_IRQ_DISABLED: begin
        cond = !status_q[FLAG_I]; // RQ12
      end
      default: begin
        is_branch = 1'b0;
      end
    endcase
  end

  // next state of flags, pc, results and cycle count
  always_comb begin
    status_d = status_q;
    remain_d = remain_q;
    pc_d = pc_q;
    cycles_d = cycles_q;
    done_d = 1'b0;
    reg_wr_d = '0;
    res = instr_in.reg_val;
    // a flag-changing op accepted in this cycle overrides the load
    if (status_wr_in) begin
      status_d = status_wdata_in;
    end
    if (remain_q != 2'h0) begin
      remain_d = remain_q - 2'h1;
      done_d = (remain_q == 2'h1);
    end else if (accept) begin
      pc_d = PC_W'(pc_in + PC_W'(1));
      cycles_d = CYC_ONE;
      if (is_branch) begin
        if (cond) begin
          pc_d = rel_target(pc_in, instr_in.offset); // RQ3
          cycles_d = CYC_TWO; // RQ13
        end
      end else if (is_skip) begin
        if (cond && instr_in.next_two_word) begin
          pc_d = PC_W'(pc_in + PC_W'(3)); // RQ1
          cycles_d = CYC_THREE; // RQ13
        end else if (cond) begin
          pc_d = PC_W'(pc_in + PC_W'(2)); // RQ2
          cycles_d = CYC_TWO; // RQ13
        end
      end else begin
        case (instr_in.op)
          OP_IO_BIT_FORCE_ONE, OP_IO_BIT_FORCE_ZERO: begin
            cycles_d = CYC_TWO; // RQ14
          end
          OP_SHIFT_LEFT_LOGICAL: begin
            res = {instr_in.reg_val[6:0], 1'b0}; // RQ15
            status_d = shift_flags(status_q, res, instr_in.reg_val[7]);
            reg_wr_d = '{en: 1'b1, data: res};
          end
          OP_SHIFT_RIGHT_LOGICAL: begin
            res = {1'b0, instr_in.reg_val[7:1]}; // RQ16
            status_d = shift_flags(status_q, res, instr_in.reg_val[0]);
            reg_wr_d = '{en: 1'b1, data: res};
          end
          OP_ROTATE_LEFT_CARRY: begin
            res = {instr_in.reg_val[6:0], status_q[FLAG_C]}; // RQ17
            status_d = shift_flags(status_q, res, instr_in.reg_val[7]);
            reg_wr_d = '{en: 1'b1, data: res};
          end
          OP_ROTATE_RIGHT_CARRY: begin
            res = {status_q[FLAG_C], instr_in.reg_val[7:1]}; // RQ18
            status_d = shift_flags(status_q, res, instr_in.reg_val[0]);
            reg_wr_d = '{en: 1'b1, data: res};
          end
          OP_SHIFT_RIGHT_ARITH: begin
            res = {instr_in.reg_val[7], instr_in.reg_val[7:1]}; // RQ19
            status_d = shift_flags(status_q, res, instr_in.reg_val[0]);
            reg_wr_d = '{en: 1'b1, data: res};
          end
          OP_NIBBLE_SWAP: begin
            res = {instr_in.reg_val[3:0], instr_in.reg_val[7:4]};
            reg_wr_d = '{en: 1'b1, data: res};
          end
          OP_FLAG_INDEX_ON: begin
            status_d = status_q;
            status_d[instr_in.bit_idx] = 1'b1;
          end
          OP_FLAG_INDEX_OFF: begin
            status_d = status_q;
            status_d[instr_in.bit_idx] = 1'b0;
          end
          OP_BIT_TO_TRANSFER: begin
            status_d = status_q;
            status_d[FLAG_T] = instr_in.reg_val[instr_in.bit_idx]; // RQ20
          end
          OP_TRANSFER_TO_BIT: begin
            res[instr_in.bit_idx] = status_q[FLAG_T]; // RQ21
            reg_wr_d = '{en: 1'b1, data: res};
          end
          OP_CARRY_FLAG_ON: begin
            status_d = status_q;
            status_d[FLAG_C] = 1'b1; // RQ22
          end
          OP_CARRY_FLAG_OFF: begin
            status_d = status_q;
            status_d[FLAG_C] = 1'b0; // RQ22
          end
          OP_NEGATIVE_FLAG_ON: begin
            status_d = status_q;
            status_d[FLAG_N] = 1'b1; // RQ22
          end
          OP_NEGATIVE_FLAG_OFF: begin
            status_d = status_q;
            status_d[FLAG_N] = 1'b0; // RQ22
          end
          default: begin
            res = instr_in.reg_val;
          end
        endcase
      end
      // one cycle spent now, the rest held off with ready low
      remain_d = cycles_d - 2'h1; // RQ13
      done_d = (cycles_d == CYC_ONE);
    end
  end

  // io write group: byte read at accept, queued during the stall, written out on io_wr_out the cycle after it
  always_comb begin
    io_pend_d = io_pend_q;
    io_wr_d = '0;
    if (remain_q != 2'h0) begin
      if (io_pend_q.en) begin
        io_wr_d = io_pend_q;
        io_pend_d = '0;
      end
    end else if (accept && io_force) begin
      io_pend_d.en = 1'b1;
      io_pend_d.addr = instr_in.io_addr;
      io_pend_d.data = io_rd_data_in;
      io_pend_d.data[instr_in.bit_idx] = io_force_one; // RQ14
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_q <= '0;
    end else begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      remain_q <= 2'h0;
    end else begin
      remain_q <= remain_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cycles_q <= 2'h0;
    end else begin
      cycles_q <= cycles_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_wr_q <= '0;
    end else begin
      reg_wr_q <= reg_wr_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_pend_q <= '0;
      io_wr_q <= '0;
    end else begin
      io_pend_q <= io_pend_d;
      io_wr_q <= io_wr_d;
    end
  end

  assign status_out = status_q;
  assign pc_out = pc_q;
  assign cycles_out = cycles_q;
  assign done_out = done_q;
  assign reg_wr_out = reg_wr_q;
  assign io_wr_out = io_wr_q;

endmodule : branch_bit_instruction_exec
`default_nettype wire

/* File: hw/bit_exec_pkg.sv */
`default_nettype none
package bit_exec_pkg;

  localparam int PC_WIDTH = 11;
  localparam int IO_ADDR_W = 5;
  localparam int OFFSET_W = 7;

  // status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_SKIP_IO_BIT_CLEAR = 6'h01,
    OP_SKIP_IO_BIT_SET = 6'h02,
    OP_BRANCH_FLAG_INDEX_SET = 6'h03,
    OP_BRANCH_FLAG_INDEX_CLEAR = 6'h04,
    OP_BRANCH_EQUAL = 6'h05,
    OP_BRANCH_NOT_EQUAL = 6'h06,
    OP_BRANCH_CARRY_SET = 6'h07,
    OP_BRANCH_CARRY_CLEAR = 6'h08,
    OP_BRANCH_SAME_HIGHER = 6'h09,
    OP_BRANCH_LOWER = 6'h0A,
    OP_BRANCH_MINUS = 6'h0B,
    OP_BRANCH_PLUS = 6'h0C,
    OP_BRANCH_SIGNED_GE = 6'h0D,
    OP_BRANCH_SIGNED_LT = 6'h0E,
    OP_BRANCH_HALF_CARRY_SET = 6'h0F,
    OP_BRANCH_HALF_CARRY_CLEAR = 6'h10,
    OP_BRANCH_TRANSFER_SET = 6'h11,
    OP_BRANCH_TRANSFER_CLEAR = 6'h12,
    OP_BRANCH_OVERFLOW_SET = 6'h13,
    OP_BRANCH_OVERFLOW_CLEAR = 6'h14,
    OP_BRANCH_IRQ_ENABLED = 6'h15,
    OP_BRANCH_IRQ_DISABLED = 6'h16,
    OP_IO_BIT_FORCE_ONE = 6'h17,
    OP_IO_BIT_FORCE_ZERO = 6'h18,
    OP_SHIFT_LEFT_LOGICAL = 6'h19,
    OP_SHIFT_RIGHT_LOGICAL = 6'h1A,
    OP_ROTATE_LEFT_CARRY = 6'h1B,
    OP_ROTATE_RIGHT_CARRY = 6'h1C,
    OP_SHIFT_RIGHT_ARITH = 6'h1D,
    OP_NIBBLE_SWAP = 6'h1E,
    OP_FLAG_INDEX_ON = 6'h1F,
    OP_FLAG_INDEX_OFF = 6'h20,
    OP_BIT_TO_TRANSFER = 6'h21,
    OP_TRANSFER_TO_BIT = 6'h22,
    OP_CARRY_FLAG_ON = 6'h23,
    OP_CARRY_FLAG_OFF = 6'h24,
    OP_NEGATIVE_FLAG_ON = 6'h25,
    OP_NEGATIVE_FLAG_OFF = 6'h26
  } op_e;

  typedef struct packed {
    op_e op;
    logic [2:0] bit_idx;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [OFFSET_W-1:0] offset;
    logic [7:0] reg_val;
    logic next_two_word;
  } instr_s;

  typedef struct packed {
    logic en;
    logic [IO_ADDR_W-1:0] addr;
    logic [7:0] data;
  } io_wr_s;

  typedef struct packed {
    logic en;
    logic [7:0] data;
  } reg_wr_s;

endpackage : bit_exec_pkg
`default_nettype wire

/* File: sim/branch_exec_asserts.sv */
`default_nettype none
module branch_exec_asserts
  import bit_exec_pkg::*;
#(
  parameter int PC_W = PC_WIDTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire instr_s instr_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0] io_rd_data_in,
  input wire logic status_wr_in,
  input wire logic [7:0] status_wdata_in,
  input wire logic ready_out,
  input wire logic [IO_ADDR_W-1:0] io_rd_addr_out,
  input wire io_wr_s io_wr_out,
  input wire reg_wr_s reg_wr_out,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [7:0] status_out,
  input wire logic [1:0] cycles_out,
  input wire logic done_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic acc;
  logic [PC_W-1:0] tgt;
  logic [7:0] rv, iob;
  op_e op;
  assign acc = instr_valid_in && ready_out;
  assign op = instr_in.op;
  assign rv = instr_in.reg_val;
  assign tgt = pc_in + PC_W'(signed'(instr_in.offset)) + 1'b1;
  assign iob = io_rd_data_in | (8'h01 << instr_in.bit_idx);
  eq_taken_a: assert property (
    acc && op == OP_BRANCH_EQUAL && status_out[FLAG_Z] |=> pc_out == $past(tgt)
    && cycles_out == CYC_TWO && !ready_out ##1 ready_out && done_out)
    else $error("taken branch target or timing wrong");
  ne_untaken_a: assert property (
    acc && op == OP_BRANCH_NOT_EQUAL && status_out[FLAG_Z] |=> done_out
    && ready_out && cycles_out == CYC_ONE && pc_out == $past(pc_in) + 1'b1)
    else $error("untaken branch wrong");
  lt_taken_a: assert property (
    acc && op == OP_BRANCH_SIGNED_LT
    && (status_out[FLAG_N] ^ status_out[FLAG_V])
    |=> pc_out == $past(tgt)) else $error("signed less-than not taken");
  skip_three_a: assert property (
    acc && op == OP_SKIP_IO_BIT_CLEAR && !io_rd_data_in[instr_in.bit_idx]
    && instr_in.next_two_word |=> pc_out == $past(pc_in) + 2'h3
    && !ready_out ##1 !ready_out ##1 done_out) else $error("skip of three");
  force_one_a: assert property (
    acc && op == OP_IO_BIT_FORCE_ONE |=> !ready_out && !io_wr_out.en
    ##1 io_wr_out.en && io_wr_out.data == $past(iob, 2))
    else $error("io bit force one wrong");
  flags_kept_a: assert property (
    acc && op inside {[OP_SKIP_IO_BIT_CLEAR:OP_IO_BIT_FORCE_ZERO]}
    && !status_wr_in |=> $stable(status_out)) else $error("flags changed");
  shl_a: assert property (
    acc && op == OP_SHIFT_LEFT_LOGICAL |=> reg_wr_out.en && status_out[FLAG_C]
    == $past(rv[7]) && reg_wr_out.data == {$past(rv[6:0]), 1'b0})
    else $error("left shift wrong");
  rotate_right_a: assert property (
    acc && op == OP_ROTATE_RIGHT_CARRY |=> status_out[FLAG_C] == $past(rv[0])
    && reg_wr_out.data == {$past(status_out[FLAG_C]), $past(rv[7:1])})
    else $error("rotate right wrong");
  bit_store_a: assert property (
    acc && op == OP_BIT_TO_TRANSFER && !status_wr_in |=> status_out ==
    ($past(status_out) & 8'hBF | {1'b0, $past(rv[instr_in.bit_idx]), 6'h00}))
    else $error("bit store wrong");
  carry_on_a: assert property (
    acc && op == OP_CARRY_FLAG_ON && !status_wr_in |=>
    status_out == ($past(status_out) | 8'h01)) else $error("carry set wrong");
  cover property (acc && op == OP_BRANCH_EQUAL && status_out[FLAG_Z]);
  cover property (acc && op == OP_SKIP_IO_BIT_CLEAR);
  cover property (acc && op == OP_IO_BIT_FORCE_ONE);
endmodule : branch_exec_asserts
bind branch_bit_instruction_exec branch_exec_asserts #(.PC_W(PC_W)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
  .instr_valid_in(instr_valid_in), .pc_in(pc_in), .pc_out(pc_out),
  .io_rd_data_in(io_rd_data_in), .status_wr_in(status_wr_in),
  .status_wdata_in(status_wdata_in), .ready_out(ready_out),
  .io_rd_addr_out(io_rd_addr_out), .io_wr_out(io_wr_out),
  .reg_wr_out(reg_wr_out), .status_out(status_out),
  .cycles_out(cycles_out), .done_out(done_out));
`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb
  import bit_exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, swr = 1'b0, rdy, dn, rc;
  instr_s ins = '0;
  logic [PC_WIDTH-1:0] pc = '0, pco, ep;
  logic [7:0] swd = '0, sto, io_mem [32];
  logic [7:0] sts [3] = '{8'h00, 8'h5A, 8'hA5};
  logic [4:0] ioa;
  logic [1:0] cy;
  io_wr_s iow, iow_c;
  reg_wr_s rw, rw_c;
  int miscompares = 0, total_checks = 0, n, tick = 0;
  always #4 clk = ~clk;
  branch_bit_instruction_exec u_dut (.sys_clk_in(clk), .rst_n_in(rst_n),
    .instr_valid_in(vld), .instr_in(ins), .pc_in(pc),
    .io_rd_data_in(io_mem[ioa]), .status_wr_in(swr), .status_wdata_in(swd),
    .ready_out(rdy), .io_rd_addr_out(ioa), .io_wr_out(iow),
    .reg_wr_out(rw), .pc_out(pco), .status_out(sto), .cycles_out(cy),
    .done_out(dn));
  always @(posedge clk) begin
    if (iow.en === 1'b1) io_mem[iow.addr] <= iow.data;
    tick++;
    if (tick > 5000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic set_st(input logic [7:0] v);
    @(posedge clk);
    swr <= 1'b1;
    swd <= v;
    @(posedge clk);
    swr <= 1'b0;
  endtask : set_st
  task automatic exec(input op_e op, input logic [2:0] b,
    input logic [6:0] k, input logic [7:0] r, input logic two);
    @(posedge clk);
    vld <= 1'b1;
    ins <= '{op, b, 5'h05, k, r, two};
    pc <= pc + 11'h0A5;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    rc = rdy;
    n = 1;
    while (dn !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    iow_c = iow;
    rw_c = rw;
  endtask : exec
  function automatic logic taken(input op_e op, input logic [7:0] s,
    input logic [2:0] b);
    case (op)
      OP_BRANCH_FLAG_INDEX_SET: return s[b];
      OP_BRANCH_FLAG_INDEX_CLEAR: return !s[b];
      OP_BRANCH_EQUAL: return s[FLAG_Z];
      OP_BRANCH_NOT_EQUAL: return !s[FLAG_Z];
      OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: return s[FLAG_C];
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER: return !s[FLAG_C];
      OP_BRANCH_MINUS: return s[FLAG_N];
      OP_BRANCH_PLUS: return !s[FLAG_N];
      OP_BRANCH_SIGNED_GE: return !(s[FLAG_N] ^ s[FLAG_V]);
      OP_BRANCH_SIGNED_LT: return s[FLAG_N] ^ s[FLAG_V];
      OP_BRANCH_HALF_CARRY_SET: return s[FLAG_H];
      OP_BRANCH_HALF_CARRY_CLEAR: return !s[FLAG_H];
      OP_BRANCH_TRANSFER_SET: return s[FLAG_T];
      OP_BRANCH_TRANSFER_CLEAR: return !s[FLAG_T];
      OP_BRANCH_OVERFLOW_SET: return s[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR: return !s[FLAG_V];
      OP_BRANCH_IRQ_ENABLED: return s[FLAG_I];
      default: return !s[FLAG_I];
    endcase
  endfunction : taken
  // returns carry out then result
  function automatic logic [8:0] sh(input op_e op, input logic [7:0] r,
    input logic c);
    case (op)
      OP_SHIFT_LEFT_LOGICAL: return {r, 1'b0};
      OP_SHIFT_RIGHT_LOGICAL: return {r[0], 1'b0, r[7:1]};
      OP_ROTATE_LEFT_CARRY: return {r, c};
      OP_ROTATE_RIGHT_CARRY: return {r[0], c, r[7:1]};
      default: return {r[0], r[7], r[7:1]};
    endcase
  endfunction : sh
  initial begin
    logic [6:0] k;
    logic [8:0] r9;
    logic [7:0] e8, r;
    logic tk;
    op_e opx;
    foreach (io_mem[i]) io_mem[i] = 8'h00;
    io_mem[5] = 8'h5A;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (sts[i]) begin
      set_st(sts[i]);
      for (int o = OP_BRANCH_FLAG_INDEX_SET; o <= OP_BRANCH_IRQ_DISABLED; o++)
      begin
        k = 7'(o * 19);
        exec(op_e'(o), 3'(o), k, 8'h00, 1'b0);
        tk = taken(op_e'(o), sts[i], 3'(o));
        ep = tk ? pc + {{4{k[6]}}, k} + 11'h001 : pc + 11'h001;
        `CHK("pc", ep, pco)
        `CHK("cycles", {2{2'h1 + 2'(tk)}}, {n[1:0], cy})
        `CHK("ready", !tk, rc)
        `CHK("status", sts[i], sto)
      end
    end
    for (int j = 0; j < 32; j++) begin
      opx = j[4] ? OP_SKIP_IO_BIT_SET : OP_SKIP_IO_BIT_CLEAR;
      exec(opx, 3'(j), 7'h00, 8'h00, j[3]);
      e8 = 8'h5A;
      tk = e8[j % 8] === j[4];
      `CHK("skip pc", pc + (tk ? 11'h002 + j[3] : 11'h001), pco)
      `CHK("skip cycles", {2{tk ? 2'h2 + j[3] : 2'h1}}, {n[1:0], cy})
      `CHK("skip status", 8'hA5, sto)
    end
    exec(OP_IO_BIT_FORCE_ONE, 3'h0, 7'h00, 8'h00, 1'b0);
    `CHK("force one", {1'b1, 5'h05, 8'h5B, 2'h2}, {iow_c, n[1:0]})
    exec(OP_IO_BIT_FORCE_ZERO, 3'h1, 7'h00, 8'h00, 1'b0);
    `CHK("force zero", {1'b1, 5'h05, 8'h59, 2'h2}, {iow_c, cy})
    `CHK("force status", 8'hA5, sto)
    for (int q = 0; q < 20; q++) begin
      opx = op_e'(OP_SHIFT_LEFT_LOGICAL + q % 5);
      r = (q / 5) % 2 ? 8'h81 : 8'h01;
      e8 = q < 10 ? 8'hFE : 8'hFF;
      set_st(e8);
      exec(opx, 3'h0, 7'h00, r, 1'b0);
      r9 = sh(opx, r, e8[FLAG_C]);
      e8[FLAG_C] = r9[8];
      e8[FLAG_Z] = r9[7:0] == 8'h00;
      e8[FLAG_N] = r9[7];
      e8[FLAG_V] = r9[7] ^ r9[8];
      `CHK("shift data", {1'b1, r9[7:0]}, rw_c)
      `CHK("shift flags", e8, sto)
    end
    set_st(8'h00);
    exec(OP_BIT_TO_TRANSFER, 3'h2, 7'h00, 8'h04, 1'b0);
    `CHK("bit store", 8'h40, sto)
    exec(OP_TRANSFER_TO_BIT, 3'h7, 7'h00, 8'h01, 1'b0);
    `CHK("bit load", {1'b1, 8'h81, 8'h40}, {rw_c, sto})
    for (int q = 0; q < 4; q++) begin
      e8 = q[0] ? 8'hA5 : 8'h5A;
      set_st(e8);
      exec(op_e'(OP_CARRY_FLAG_ON + q), 3'h0, 7'h00, 8'h00, 1'b0);
      e8[q < 2 ? FLAG_C : FLAG_N] = !q[0];
      `CHK("flag op", e8, sto)
    end
    test_done();
  end
endmodule : tb
`default_nettype wire
